// File: nvac_array_model.sv
// byte array model behind the nv access block, with rc oscillator
`timescale 1ns/1ps
module nvac_array_model (
	input  wire logic       hclk,
	input  wire logic [9:0] arr_addr,
	input  wire logic [7:0] arr_wdata,
	input  wire logic       arr_erase,
	input  wire logic       arr_write,
	output logic [7:0]      arr_rdata,
	output logic            rc_osc
);
	logic [7:0] mem [1024];

	// preset pattern; oscillator period of eight system cycles
	initial begin
		for (int i = 0; i < 1024; i++)
			mem[i] = i[7:0] ^ 8'hA5;
		rc_osc = 1'b0;
	end
	always #160 rc_osc = ~rc_osc;

	// erase sets ones, write clears bits, both store the new byte
	always @(posedge hclk) begin
		if (arr_erase && arr_write)
			mem[arr_addr] <= arr_wdata;
		else if (arr_erase)
			mem[arr_addr] <= 8'hFF;
		else if (arr_write)
			mem[arr_addr] <= mem[arr_addr] & arr_wdata;
	end
	assign arr_rdata = mem[arr_addr];
endmodule

// File: nvac_pkg.sv
// package: register map, field layout and timing counts of the nv access block
package nvac_pkg;

	// ----------------------------------------------------------------
	// register indices and byte addresses (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [7:0]  NVAC_IDX_CTRL   = 8'h3F;
	localparam logic [7:0]  NVAC_IDX_DATA   = 8'h40;
	localparam logic [7:0]  NVAC_IDX_ADRL   = 8'h41;
	localparam logic [7:0]  NVAC_IDX_ADRH   = 8'h42;
	localparam logic [7:0]  NVAC_IDX_STAT   = 8'h43;
	localparam logic [7:0]  NVAC_IDX_NONE   = 8'h00;
	localparam logic [21:0] NVAC_HI_ZERO    = 22'h000000;

	// ----------------------------------------------------------------
	// nv_access_control field positions
	// ----------------------------------------------------------------
	localparam int NVAC_B_READ   = 0;
	localparam int NVAC_B_STROBE = 1;
	localparam int NVAC_B_ARM    = 2;
	localparam int NVAC_B_IRQEN  = 3;
	localparam int NVAC_B_MODE0  = 4;
	localparam int NVAC_B_MODE1  = 5;

	// status register field positions
	localparam int NVAC_S_BUSY   = 0;
	localparam int NVAC_S_SPA    = 1;
	localparam int NVAC_S_IRQ    = 2;

	// ----------------------------------------------------------------
	// program modes
	// ----------------------------------------------------------------
	localparam logic [1:0] NVAC_MODE_ATOMIC = 2'h0;
	localparam logic [1:0] NVAC_MODE_ERASE  = 2'h1;
	localparam logic [1:0] NVAC_MODE_WRITE  = 2'h2;
	localparam logic [1:0] NVAC_MODE_RSVD   = 2'h3;

	// ----------------------------------------------------------------
	// reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic [1:0]  NVAC_MODE_RST   = 2'h0;
	localparam logic [7:0]  NVAC_DATA_RST   = 8'h00;
	localparam logic [9:0]  NVAC_ADDR_RST   = 10'h000;
	localparam logic [2:0]  NVAC_ARM_WIN    = 3'h4;
	localparam logic [2:0]  NVAC_STALL_PROG = 3'h2;
	localparam logic [2:0]  NVAC_STALL_READ = 3'h4;
	// oscillator cycles for one program operation
	localparam int unsigned NVAC_RC_FULL_DEF  = 26368;
	localparam int unsigned NVAC_RC_SPLIT_DEF = 13184;
	localparam int unsigned NVAC_PROG_TIME_US = 3300;

endpackage

// File: nvac_prog_engine.sv
// program engine: mode field, oscillator timed operation, latched target
`timescale 1ns/1ps
module nvac_prog_engine import nvac_pkg::*; #(
	parameter int unsigned RC_FULL  = NVAC_RC_FULL_DEF,
	parameter int unsigned RC_SPLIT = NVAC_RC_SPLIT_DEF
) (
	input  wire logic       hclk,
	input  wire logic       por_n,
	input  wire logic       sys_rst_n,
	input  wire logic       rc_rise,
	input  wire logic       start,
	input  wire logic       mode_wr,
	input  wire logic [1:0] mode_wdata,
	input  wire logic [9:0] op_addr_in,
	input  wire logic [7:0] op_data_in,
	output logic            busy,
	output logic [1:0]      mode,
	output logic [9:0]      op_addr,
	output logic [7:0]      op_data,
	output logic            arr_erase,
	output logic            arr_write
);

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [1:0]  mode;
		logic [14:0] cnt;
		logic [9:0]  addr;
		logic [7:0]  data;
	} nvac_eng_t;

	nvac_eng_t  r;
	nvac_eng_t  nxt_r;
	logic [1:0] eff_mode;
	logic [14:0] last_cnt;

	// ----------------------------------------------------------------
	// mode update, start, oscillator count and completion
	// ----------------------------------------------------------------
	always_comb begin
		nxt_r      = r;
		nxt_r.done = 1'b0;
		eff_mode   = mode_wr ? mode_wdata : r.mode;
		// [RL1] duration per mode, from the frozen mode of the operation
		last_cnt   = (r.mode == NVAC_MODE_ATOMIC) ?
		             15'(RC_FULL - 1) : 15'(RC_SPLIT - 1);
		if (!r.busy) begin
			// [RL2] mode frozen while busy
			if (mode_wr) begin
				nxt_r.mode = mode_wdata;
			end
			// [RL19] reserved mode does nothing
			if (start && eff_mode != NVAC_MODE_RSVD) begin
				nxt_r.busy = 1'b1;
				nxt_r.cnt  = '0;
				nxt_r.addr = op_addr_in;
				nxt_r.data = op_data_in;
			end
			// [RL3] mode cleared by idle system reset
			if (!sys_rst_n) begin
				nxt_r.mode = NVAC_MODE_RST;
			end
		end else if (rc_rise) begin
			// [RL16] timed on oscillator cycles
			if (r.cnt == last_cnt) begin
				// [RL12] strobe clears when done
				nxt_r.busy = 1'b0;
				nxt_r.done = 1'b1;
			end else begin
				nxt_r.cnt = r.cnt + 15'h0001;
			end
		end
	end

	// [RL20] only power-on reset stops a running operation
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			r <= '0;
		end else begin
			r <= nxt_r;
		end
	end

	assign busy      = r.busy;
	assign mode      = r.mode;
	assign op_addr   = r.addr;
	assign op_data   = r.data;
	assign arr_erase = r.done & (r.mode != NVAC_MODE_WRITE);
	assign arr_write = r.done & (r.mode != NVAC_MODE_ERASE);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// [RL2] mode stable
	mode_hold_a: assert property (@(posedge hclk) disable iff (!por_n) // RL2
		r.busy |=> $stable(r.mode))
		else $error("mode changed during programming");
	// [RL19] reserved
	rsvd_noop_a: assert property (@(posedge hclk) disable iff (!por_n) // RL19
		(start && !r.busy && eff_mode == NVAC_MODE_RSVD) |=> !r.busy)
		else $error("reserved mode started an operation");
	// [RL3] reset clear
	mode_reset_a: assert property (@(posedge hclk) disable iff (!por_n) // RL3
		(!sys_rst_n && !r.busy && !start) |=> r.mode == NVAC_MODE_RST)
		else $error("mode not cleared by idle reset");
	// [RL12] done ends busy
	done_clear_a: assert property (@(posedge hclk) disable iff (!por_n) // RL12
		r.done |-> !r.busy && $past(r.busy))
		else $error("completion without preceding busy");

endmodule

// File: nvac_sync3.sv
// three-stage synchroniser with agreement filter and rising edge pulse
`timescale 1ns/1ps
module nvac_sync3 (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic din,
	output logic      rise
);

	typedef struct packed {
		logic [2:0] s;
		logic       lvl;
	} nvac_sync_t;

	nvac_sync_t r;
	nvac_sync_t nxt_r;

	// ----------------------------------------------------------------
	// shift chain, level accepted once stages two and three agree
	// ----------------------------------------------------------------
	always_comb begin
		nxt_r   = r;
		nxt_r.s = {r.s[1:0], din};
		if (r.s[1] == r.s[2]) begin
			nxt_r.lvl = r.s[2];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= nxt_r;
		end
	end

	// one pulse per accepted low to high change
	assign rise = r.s[1] & r.s[2] & ~r.lvl;

endmodule

// File: nvac_top.sv
// nv byte access control: AHB-Lite registers, arm window, stalls, irq
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Operation
// [RL1] mode 00 erase plus write, 01 erase only, 10 write only
// [RL2] mode field writes ignored while program strobe is set
// [RL3] reset clears mode to 00 unless programming is in progress
// [RL4] ready irq needs its enable and the global interrupt enable
// [RL5] ready irq held while strobe clear, never during write or flash
// [RL6] strobe starts programming only within four cycles of arming
// [RL7] strobe with arm clear does nothing
// [RL8] hardware clears the arm bit four cycles after it is set
// [RL9] software waits idle, arms with strobe zero, then strobes
// [RL10] no programming while flash self-programming is active
// [RL11] software keeps interrupts off during the write sequence
// [RL12] hardware clears the strobe when programming time has elapsed
// [RL13] program start stalls the cpu for two cycles
// [RL14] read strobe loads data at once and stalls four cycles
// [RL15] reads and address changes blocked during a write
// [RL16] programming timed by oscillator, 26368 cycles for a full write
// [RL17] address selects one of 1024 bytes, 0 to 1023
// [RL18] data register holds write byte and receives read byte
// [RL19] reserved mode 11 does nothing and clears the strobe
// [RL20] running operation completes through reset, mode kept
module nvac_top import nvac_pkg::*; #(
	parameter int unsigned RC_FULL  = NVAC_RC_FULL_DEF,
	parameter int unsigned RC_SPLIT = NVAC_RC_SPLIT_DEF
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        por_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        rc_osc,
	input  wire logic        self_program_active,
	input  wire logic        global_irq_enable,
	output logic [9:0]       arr_addr,
	output logic [7:0]       arr_wdata,
	input  wire logic [7:0]  arr_rdata,
	output logic             arr_erase,
	output logic             arr_write,
	output logic             ready_irq,
	output logic             cpu_stall
);

	typedef struct packed {
		logic        dwr;
		logic [7:0]  widx;
		logic [31:0] rdata;
		logic        irq_en;
		logic        arm;
		logic [2:0]  arm_cnt;
		logic [9:0]  addr;
		logic [7:0]  data;
		logic [2:0]  stall;
	} nvac_main_t;

	nvac_main_t r;
	nvac_main_t nxt_r;

	logic       rc_rise;
	logic       busy;
	logic [1:0] mode;
	logic [9:0] op_addr;
	logic [7:0] op_data;
	logic       start;
	logic       mode_wr;
	logic       rd_go;
	logic       addr_ok;
	logic [7:0] aidx;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// map a bus address to a register index, or none
	function automatic logic [7:0] reg_sel(input logic [31:0] a);
		logic [7:0] i;
		i = a[9:2];
		if (a[31:10] != NVAC_HI_ZERO) begin
			return NVAC_IDX_NONE;
		end
		if (i >= NVAC_IDX_CTRL && i <= NVAC_IDX_STAT) begin
			return i;
		end
		return NVAC_IDX_NONE;
	endfunction

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	nvac_sync3 u_rc_sync (
		.clk   (hclk),
		.rst_n (por_n),
		.din   (rc_osc),
		.rise  (rc_rise)
	);

	nvac_prog_engine #(
		.RC_FULL  (RC_FULL),
		.RC_SPLIT (RC_SPLIT)
	) u_engine (
		.hclk       (hclk),
		.por_n      (por_n),
		.sys_rst_n  (hresetn),
		.rc_rise    (rc_rise),
		.start      (start),
		.mode_wr    (mode_wr),
		.mode_wdata (hwdata[NVAC_B_MODE1:NVAC_B_MODE0]),
		.op_addr_in (r.addr),
		.op_data_in (r.data),
		.busy       (busy),
		.mode       (mode),
		.op_addr    (op_addr),
		.op_data    (op_data),
		.arr_erase  (arr_erase),
		.arr_write  (arr_write)
	);

	// ----------------------------------------------------------------
	// bus slave and register side
	// ----------------------------------------------------------------
	always_comb begin
		nxt_r   = r;
		start   = 1'b0;
		mode_wr = 1'b0;
		rd_go   = 1'b0;
		addr_ok = hsel & htrans[1] & hready;
		aidx    = reg_sel(haddr);
		nxt_r.dwr = 1'b0;
		// [RL8] arm times out after four cycles
		if (r.arm) begin
			nxt_r.arm_cnt = r.arm_cnt - 3'h1;
			if (r.arm_cnt == 3'h1) begin
				nxt_r.arm = 1'b0;
			end
		end
		if (r.stall != 3'h0) begin
			nxt_r.stall = r.stall - 3'h1;
		end
		// write data phase commit
		if (r.dwr) begin
			unique case (r.widx)
				NVAC_IDX_CTRL: begin
					mode_wr      = 1'b1;
					nxt_r.irq_en = hwdata[NVAC_B_IRQEN];
					if (hwdata[NVAC_B_ARM]) begin
						nxt_r.arm     = 1'b1;
						nxt_r.arm_cnt = NVAC_ARM_WIN;
					end
					// [RL6] [RL7] [RL10] start needs arm, idle, no flash
					if (hwdata[NVAC_B_STROBE] && r.arm && !busy &&
					    !self_program_active) begin
						start = 1'b1;
						// [RL13] two stall cycles
						nxt_r.stall = NVAC_STALL_PROG;
					end
					// [RL14] read loads data at once
					if (hwdata[NVAC_B_READ] && !busy) begin
						rd_go       = 1'b1;
						nxt_r.data  = arr_rdata;
						nxt_r.stall = NVAC_STALL_READ;
					end
				end
				// [RL18] write byte, locked while busy
				NVAC_IDX_DATA: begin
					if (!busy) begin
						nxt_r.data = hwdata[7:0];
					end
				end
				// [RL15] address locked while busy
				NVAC_IDX_ADRL: begin
					if (!busy) begin
						nxt_r.addr[7:0] = hwdata[7:0];
					end
				end
				// [RL17] ten address bits
				NVAC_IDX_ADRH: begin
					if (!busy) begin
						nxt_r.addr[9:8] = hwdata[1:0];
					end
				end
				default: ;
			endcase
		end
		// address phase: writes wait one cycle, reads answer next
		if (addr_ok) begin
			if (hwrite) begin
				nxt_r.dwr  = 1'b1;
				nxt_r.widx = aidx;
			end else begin
				nxt_r.rdata = 32'h00000000;
				unique case (aidx)
					NVAC_IDX_CTRL: begin
						nxt_r.rdata[NVAC_B_MODE1:NVAC_B_MODE0] = mode;
						nxt_r.rdata[NVAC_B_IRQEN]  = r.irq_en;
						nxt_r.rdata[NVAC_B_ARM]    = r.arm;
						nxt_r.rdata[NVAC_B_STROBE] = busy;
					end
					NVAC_IDX_DATA: nxt_r.rdata[7:0] = r.data;
					NVAC_IDX_ADRL: nxt_r.rdata[7:0] = r.addr[7:0];
					NVAC_IDX_ADRH: nxt_r.rdata[1:0] = r.addr[9:8];
					NVAC_IDX_STAT: begin
						nxt_r.rdata[NVAC_S_BUSY] = busy;
						nxt_r.rdata[NVAC_S_SPA]  = self_program_active;
						nxt_r.rdata[NVAC_S_IRQ]  = ready_irq;
					end
					default: ;
				endcase
			end
		end
	end

	// register state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r         <= '0;
			r.widx    <= NVAC_IDX_NONE;
			r.addr    <= NVAC_ADDR_RST;
			r.data    <= NVAC_DATA_RST;
		end else begin
			r <= nxt_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// stall by holding the bus: write wait state plus cpu halt cycles
	assign hreadyout = ~r.dwr & (r.stall == 3'h0);
	assign hresp     = 1'b0;
	assign hrdata    = r.rdata;
	assign cpu_stall = ~hreadyout;
	// latched target through the completion pulse, so a reset that
	// clears the address register cannot redirect the final store
	assign arr_addr  = (busy | arr_erase | arr_write) ? op_addr : r.addr;
	assign arr_wdata = op_data;
	// [RL4] [RL5] level request, blocked by write or flash
	assign ready_irq = r.irq_en & global_irq_enable & ~busy &
	                   ~self_program_active;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// [RL4] enable gating
	irq_enable_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
		(!r.irq_en || !global_irq_enable) |-> !ready_irq)
		else $error("ready irq without its enables");
	// [RL5] raised at completion
	irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
		(r.irq_en && global_irq_enable && !self_program_active &&
		 $fell(busy)) |-> ready_irq)
		else $error("ready irq missing after completion");
	// [RL5] not during write
	irq_busy_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
		busy |-> !ready_irq)
		else $error("ready irq during programming");
	// [RL7] arm required
	strobe_arm_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
		start |-> r.arm && r.arm_cnt != 3'h0)
		else $error("program started without arm");
	// [RL8] arm window length
	arm_window_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
		$rose(r.arm) |-> r.arm[*4])
		else $error("arm bit cleared too early");
	// [RL8] arm expiry
	arm_expire_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
		(r.arm && r.arm_cnt == 3'h1 && !(r.dwr && r.widx == NVAC_IDX_CTRL))
		|=> !r.arm)
		else $error("arm bit not cleared after four cycles");
	// [RL10] flash interlock
	spm_block_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
		self_program_active |-> !start)
		else $error("program started during flash write");
	// [RL13] program stall
	prog_stall_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL13
		(start && !rd_go) |=> !hreadyout[*2] ##1 hreadyout)
		else $error("program stall not two cycles");
	// [RL14] read stall and data
	read_stall_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL14
		rd_go |=> r.data == $past(arr_rdata) ##0 !hreadyout[*4]
		##1 hreadyout)
		else $error("read stall not four cycles");
	// [RL15] address lock
	addr_lock_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL15
		(busy && $past(busy)) |-> $stable(r.addr) && !rd_go)
		else $error("address changed during programming");

endmodule

// File: testbench.sv
// testbench: bus master, queued result checks, program scenarios
`timescale 1ns/1ps
module testbench import nvac_pkg::*;;
	localparam logic [31:0] A_CTL = {NVAC_HI_ZERO, NVAC_IDX_CTRL, 2'h0};
	localparam logic [31:0] A_DAT = {NVAC_HI_ZERO, NVAC_IDX_DATA, 2'h0};
	localparam logic [31:0] A_AL  = {NVAC_HI_ZERO, NVAC_IDX_ADRL, 2'h0};
	localparam logic [31:0] A_AH  = {NVAC_HI_ZERO, NVAC_IDX_ADRH, 2'h0};
	localparam logic [31:0] A_STA = {NVAC_HI_ZERO, NVAC_IDX_STAT, 2'h0};
	logic        hclk, hresetn, por_n, hsel, hwrite, hreadyout;
	logic        spa, gie, ready_irq, arr_erase, arr_write, rc_osc;
	logic        hresp, cpu_stall;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, seen;
	logic [9:0]  arr_addr;
	logic [7:0]  arr_wdata, arr_rdata;
	logic [7:0]  sh [1024];
	logic [31:0] ex_q [$];
	string       nm_q [$];
	int          error_cnt, checks_done;
	int          seed = 32'h57391C0C;
	event        seen_ev;

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic note(input string nm, input logic [31:0] e);
		nm_q.push_back(nm);
		ex_q.push_back(e);
	endtask

	task automatic show(input logic [31:0] v);
		seen = v;
		-> seen_ev;
		#1;
	endtask

	// watcher: compare each result with the oldest note
	always @(seen_ev) begin
		logic [31:0] e;
		string       n;
		e = ex_q.pop_front();
		n = nm_q.pop_front();
		checks_done++;
		if (seen !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, seen);
		end
	end

	// one single transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [31:0] a,
			input logic [31:0] d, output logic [31:0] r, output int wt);
		logic rdy;
		int   n;
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= a;
		wt = 0;
		for (int ph = 0; ph < 2; ph++) begin
			n = 0;
			do begin
				@(negedge hclk);
				rdy = (hreadyout === 1'b1);
				r   = hrdata;
				// wait cycles as seen on the cpu stall output
				if (cpu_stall !== 1'b0)
					wt++;
				@(posedge hclk);
				n++;
			end while (!rdy && n < 200);
			if (!rdy) begin
				error_cnt++;
				conclude();
			end
			// leave the address phase once, then hold the data phase
			if (ph == 0) begin
				htrans <= 2'h0;
				hsel   <= 1'b0;
				hwdata <= d;
			end
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d,
			output int wt);
		logic [31:0] r;
		bus(1'b1, a, {24'h0, d}, r, wt);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] r);
		int wt;
		bus(1'b0, a, 32'h0, r, wt);
	endtask

	task automatic rdc(input string nm, input logic [31:0] a,
			input logic [31:0] e);
		logic [31:0] r;
		note(nm, e);
		rd(a, r);
		show(r);
	endtask

	task automatic wrc(input string nm, input logic [31:0] a,
			input logic [7:0] d, input logic [31:0] ewt);
		int wt;
		note(nm, ewt);
		wr(a, d, wt);
		show(32'(wt));
	endtask

	task automatic irqp(input string nm, input logic e);
		note(nm, {30'h0, 1'b0, e});
		@(negedge hclk);
		show({30'h0, hresp, ready_irq});
		@(posedge hclk);
	endtask

	task automatic idle_wait();
		logic [31:0] r;
		int          n;
		n = 0;
		do begin
			rd(A_STA, r);
			n++;
		end while (r[NVAC_S_BUSY] !== 1'b0 && n < 300);
		if (r[NVAC_S_BUSY] !== 1'b0) begin
			error_cnt++;
			conclude();
		end
	endtask

	// software write sequence: address, data, arm, then strobe
	task automatic start(input logic [1:0] m, input logic [9:0] a,
			input logic [7:0] d);
		int wt;
		wr(A_AL, a[7:0], wt);
		wr(A_AH, {6'h0, a[9:8]}, wt);
		wr(A_DAT, d, wt);
		wr(A_CTL, {2'h0, m, 4'hC}, wt);
		if (m == NVAC_MODE_RSVD)
			wr(A_CTL, {2'h0, m, 4'hA}, wt);
		else
			wrc("prog stall", A_CTL, {2'h0, m, 4'hA}, 32'h3);
		case (m)
			NVAC_MODE_ATOMIC: sh[a] = d;
			NVAC_MODE_ERASE:  sh[a] = 8'hFF;
			NVAC_MODE_WRITE:  sh[a] = sh[a] & d;
			default:          sh[a] = sh[a];
		endcase
	endtask

	task automatic verify(input logic [9:0] a);
		int wt;
		wr(A_AL, a[7:0], wt);
		wr(A_AH, {6'h0, a[9:8]}, wt);
		wrc("read stall", A_CTL, 8'h01, 32'h5);
		rdc("byte", A_DAT, {24'h0, sh[a]});
	endtask

	nvac_top #(.RC_FULL(8), .RC_SPLIT(4)) nvac_top_inst (
		.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .rc_osc(rc_osc),
		.self_program_active(spa), .global_irq_enable(gie),
		.arr_addr(arr_addr), .arr_wdata(arr_wdata),
		.arr_rdata(arr_rdata), .arr_erase(arr_erase),
		.arr_write(arr_write), .ready_irq(ready_irq),
		.cpu_stall(cpu_stall));

	nvac_array_model nvac_array_model_inst (
		.hclk(hclk), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
		.arr_erase(arr_erase), .arr_write(arr_write),
		.arr_rdata(arr_rdata), .rc_osc(rc_osc));

	// system clock, 40 ns period
	always #20 hclk = ~hclk;

	// main sequence
	initial begin
		int         wt;
		logic [9:0] a;
		logic [7:0] d;
		hclk    = 1'b0;
		hresetn = 1'b0;
		por_n   = 1'b0;
		hsel    = 1'b0;
		hwrite  = 1'b0;
		htrans  = 2'h0;
		hsize   = 3'h2;
		haddr   = 32'h0;
		hwdata  = 32'h0;
		spa     = 1'b0;
		gie     = 1'b0;
		for (int i = 0; i < 1024; i++)
			sh[i] = i[7:0] ^ 8'hA5;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		por_n   <= 1'b1;
		@(posedge hclk);
		rdc("ctrl", A_CTL, 32'h0);
		rdc("data", A_DAT, 32'h0);
		rdc("status", A_STA, 32'h0);
		wr(32'h200, 8'h5A, wt);
		rdc("unmapped", 32'h200, 32'h0);
		wr(A_AH, 8'hFF, wt);
		rdc("addr high", A_AH, 32'h3);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			a = 10'($random(seed));
			d = 8'($random(seed));
			start(k[1:0], a, d);
			rdc("busy", A_STA, {31'h0, k != 3});
			if (k != 3) begin
				wr(A_CTL, {2'h0, ~k[1:0], 4'h1}, wt);
				wr(A_AL, ~a[7:0], wt);
				rdc("mode held", A_CTL, {26'h0, k[1:0], 4'h2});
				rdc("addr held", A_AL, {24'h0, a[7:0]});
				rdc("data held", A_DAT, {24'h0, d});
				idle_wait();
			end
			verify(a);
		end
		$display("test modes done");
		wr(A_CTL, 8'h04, wt);
		rdc("arm set", A_CTL, 32'h4);
		repeat (3) @(posedge hclk);
		rdc("arm lapsed", A_CTL, 32'h0);
		wr(A_CTL, 8'h02, wt);
		rdc("late strobe", A_STA, 32'h0);
		wr(A_CTL, 8'h06, wt);
		rdc("same write", A_STA, 32'h0);
		spa <= 1'b1;
		wr(A_CTL, 8'h04, wt);
		wr(A_CTL, 8'h02, wt);
		rdc("flash lock", A_STA, 32'h2);
		spa <= 1'b0;
		$display("test arm done");
		for (int k = 0; k < 4; k++) begin
			gie <= k[1];
			wr(A_CTL, {4'h0, k[0], 3'h0}, wt);
			irqp("irq idle", k[0] & k[1]);
		end
		spa <= 1'b1;
		irqp("irq flash", 1'b0);
		spa <= 1'b0;
		gie <= 1'b0;
		start(NVAC_MODE_WRITE, 10'h3FF, 8'h0F);
		gie <= 1'b1;
		irqp("irq busy", 1'b0);
		idle_wait();
		irqp("irq ready", 1'b1);
		gie <= 1'b0;
		verify(10'h3FF);
		$display("test irq done");
		start(NVAC_MODE_ERASE, a, d);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc("mode kept", A_CTL, 32'h12);
		idle_wait();
		verify(a);
		wr(A_CTL, 8'h20, wt);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc("mode cleared", A_CTL, 32'h0);
		$display("test reset mid op done");
		conclude();
	end
endmodule
